//--- inc/spi_sleep_map.svh
// Constant map of the sleep-aware SPI slave port
`ifndef SPI_SLEEP_MAP_SVH
`define SPI_SLEEP_MAP_SVH
// ==========================================================
// Modes and data
`define MODE_GATED   4'h4
`define MODE_FREE    4'h5
`define BYTE_BITS    4'h8
`define BUF_RST      8'h00
// ==========================================================
// Timing, core clock 50 MHz
`define CLK_NS       20
`define TCY_NS       80
`define TCY_CYC      ((`TCY_NS) / (`CLK_NS))
`define GUARD_NS     180
`define GUARD_CYC    (((`GUARD_NS) + (`CLK_NS) - 1) / (`CLK_NS))
`define WAKE_NS      1000
`define WAKE_CYC     (((`WAKE_NS) + (`CLK_NS) - 1) / (`CLK_NS))
`endif

//--- inc/spi_sleep_pkg.sv
// Types of the sleep-aware SPI slave port
package spi_sleep_pkg;
   typedef enum logic [1:0] {PWR_RUN, PWR_SLEEP, PWR_WAKE} pwr_t;
   typedef struct packed {
      logic [2:0] sclk_s;
      logic [2:0] ss_s;
      logic [1:0] sdi_s;
      logic [7:0] sh;
      logic [3:0] cnt;
      logic [7:0] serial_buffer;
      logic [7:0] rx_hold;
      logic       pend;
      logic       buffer_full_flag;
      logic       port_interrupt_flag;
      logic       write_collision_flag;
      logic       done_tgl;
      logic       ss_cont;
      logic       fault;
      logic       slp_pend;
      logic [3:0] ss_age;
      logic [6:0] wake_cnt;
      pwr_t       pwr;
   } state_t;
endpackage : spi_sleep_pkg

//--- logic/spi_slave_sleep_port.sv
// SPI slave port with the core Sleep interactions
`timescale 1ns/1ps
`include "spi_sleep_map.svh"

// Overview of operation
// - Mode 0100: slave transfers framed by the select pin.
// - Mode 0101: slave runs regardless of the select pin.
// - Gated mode: select released before wake-up buffer update loses byte.
// - Spare output toggles when buffer-full is set; master then releases.
// - Select within 1 Tcy before Sleep: rx byte dropped, buffer kept.
// - In that fault the queued MSB is sent on all eight clocks.
// - Sleep is held off until 2.25 Tcy after select goes active.
// - Spurious collision flag on Sleep mid-transfer in two listed cases.
// - Spurious collision flag never aborts the transfer in progress.
// - Clearing port enable clears transfer state, avoiding spurious flag.
module spi_slave_sleep_port (
   input  wire logic       core_clk,
   input  wire logic       reset_n,
   input  wire logic       sclk_pin,
   input  wire logic       ss_n_pin,
   input  wire logic       sdi_pin,
   output logic            sdo_out,
   output logic            sdo_oe_n,
   input  wire logic       port_enable_bit,
   input  wire logic [3:0] port_mode_field,
   input  wire logic       clk_edge_sel,
   input  wire logic       sleep_exec,
   input  wire logic       sleep_guard_en,
   input  wire logic       buf_wr,
   input  wire logic [7:0] buf_wdata,
   input  wire logic       buf_rd,
   input  wire logic       pif_clr,
   input  wire logic       write_collision_flag_clr,
   output logic [7:0]      serial_buffer,
   output logic            buffer_full_flag,
   output logic            port_interrupt_flag,
   output logic            write_collision_flag,
   output logic            done_toggle,
   output logic            asleep
);
   // ==========================================================
   // Reset release
   logic [1:0]            rst_s;
   logic                  rst_n;
   spi_sleep_pkg::state_t q;
   spi_sleep_pkg::state_t d;
   localparam spi_sleep_pkg::state_t RST_STATE = '{
      sclk_s: 3'h0, ss_s: 3'h7, sdi_s: 2'h0, sh: 8'h00, cnt: 4'h0,
      serial_buffer: `BUF_RST, rx_hold: 8'h00, pend: 1'b0,
      buffer_full_flag: 1'b0, port_interrupt_flag: 1'b0,
      write_collision_flag: 1'b0, done_tgl: 1'b0, ss_cont: 1'b0,
      fault: 1'b0, slp_pend: 1'b0, ss_age: 4'h0, wake_cnt: 7'h0,
      pwr: spi_sleep_pkg::PWR_RUN};

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         rst_s <= 2'h0;
      end else begin
         rst_s <= {rst_s[0], 1'b1};
      end
   end
   assign rst_n = rst_s[1];

   // ==========================================================
   // Decoded link view, from second and third sync stages only
   logic gated, free, slave, sel, ss_rel, sclk_rise, sclk_fall;
   logic sample, done, go, guard_block, busy;

   assign gated     = port_enable_bit && port_mode_field == `MODE_GATED;
   assign free      = port_enable_bit && port_mode_field == `MODE_FREE;
   assign slave     = gated || free;
   assign sel       = free || (gated && !q.ss_s[1]);
   assign ss_rel    = q.ss_s[1] && !q.ss_s[2];
   assign sclk_rise = q.sclk_s[1] && !q.sclk_s[2];
   assign sclk_fall = !q.sclk_s[1] && q.sclk_s[2];
   // Edge select picks the sampling edge; output moves right after it
   assign sample    = sel && (clk_edge_sel ? sclk_rise : sclk_fall);
   assign done      = sample && q.cnt == `BYTE_BITS - 4'h1;
   assign busy      = q.cnt != 4'h0;
   // Sleep deferral keeps clear of the select-to-sleep hazard
   assign guard_block = sleep_guard_en && gated && sel
                        && q.ss_age < 4'(`GUARD_CYC);
   assign go = (sleep_exec || q.slp_pend) && !guard_block
               && q.pwr == spi_sleep_pkg::PWR_RUN;

   // ==========================================================
   // Next state
   always_comb begin
      d        = q;
      d.sclk_s = {q.sclk_s[1:0], sclk_pin};
      d.ss_s   = {q.ss_s[1:0], ss_n_pin};
      d.sdi_s  = {q.sdi_s[0], sdi_pin};

      if (!sel) begin
         d.ss_age = 4'h0;
      end else if (q.ss_age != 4'hf) begin
         d.ss_age = q.ss_age + 4'h1;
      end

      if (pif_clr) begin
         d.port_interrupt_flag = 1'b0;
      end
      if (write_collision_flag_clr) begin
         d.write_collision_flag = 1'b0;
      end
      if (buf_rd) begin
         d.buffer_full_flag = 1'b0;
      end

      // Writes mid-byte are refused, as on a real collision
      if (buf_wr) begin
         if (busy) begin
            d.write_collision_flag = 1'b1;
         end else begin
            d.serial_buffer = buf_wdata;
            d.sh            = buf_wdata;
         end
      end

      if (sample) begin
         d.sh  = {q.sh[6:0], q.sdi_s[1]};
         d.cnt = q.cnt + 4'h1;
      end
      if (done) begin
         d.cnt     = 4'h0;
         d.fault   = 1'b0;
         d.ss_cont = gated; // select still low into next byte
         if (q.fault) begin
            // Received byte dropped, queued byte stays put
            d.fault = 1'b0;
            // Dropped byte still wakes the core, else it would sleep forever
            if (q.pwr == spi_sleep_pkg::PWR_SLEEP) begin
               d.pwr      = spi_sleep_pkg::PWR_WAKE;
               d.wake_cnt = 7'h0;
            end
         end else if (q.pwr == spi_sleep_pkg::PWR_RUN) begin
            d.serial_buffer       = {q.sh[6:0], q.sdi_s[1]};
            d.buffer_full_flag    = 1'b1;
            d.port_interrupt_flag = 1'b1;
            d.done_tgl            = !q.done_tgl;
         end else begin
            d.rx_hold  = {q.sh[6:0], q.sdi_s[1]};
            d.pend     = 1'b1;
            d.pwr      = spi_sleep_pkg::PWR_WAKE;
            d.wake_cnt = 7'h0;
         end
      end

      if (sleep_exec && guard_block) begin
         d.slp_pend = 1'b1;
      end
      if (go) begin
         d.slp_pend = 1'b0;
         d.pwr      = spi_sleep_pkg::PWR_SLEEP;
         if (gated && sel && !busy && q.ss_age < 4'(`TCY_CYC)) begin
            d.fault = 1'b1;
         end
         // Flag only; the shift count is left alone
         if (busy && ((free && !clk_edge_sel) || (gated && q.ss_cont))) begin
            d.write_collision_flag = 1'b1;
         end
      end

      if (q.pwr == spi_sleep_pkg::PWR_WAKE) begin
         d.wake_cnt = q.wake_cnt + 7'h1;
         if (q.pend && gated && ss_rel) begin
            d.pend = 1'b0;
         end
         if (q.wake_cnt == 7'(`WAKE_CYC - 1)) begin
            d.pwr  = spi_sleep_pkg::PWR_RUN;
            d.pend = 1'b0;
            if (q.pend && !(gated && ss_rel)) begin
               d.serial_buffer       = q.rx_hold;
               d.buffer_full_flag    = 1'b1;
               d.port_interrupt_flag = 1'b1;
               d.done_tgl            = !q.done_tgl;
            end
         end
      end

      // Gated mode with select high, or port disabled, idles the shifter
      if (!slave || (gated && q.ss_s[1])) begin
         d.cnt     = 4'h0;
         d.ss_cont = 1'b0;
         d.fault   = slave ? d.fault : 1'b0;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         q <= RST_STATE;
      end else begin
         q <= d;
      end
   end

   // ==========================================================
   // Outputs
   assign sdo_out = q.fault ? q.serial_buffer[7] : q.sh[7];
   assign sdo_oe_n             = !(slave && sel);
   assign serial_buffer        = q.serial_buffer;
   assign buffer_full_flag     = q.buffer_full_flag;
   assign port_interrupt_flag  = q.port_interrupt_flag;
   assign write_collision_flag = q.write_collision_flag;
   assign done_toggle          = q.done_tgl;
   assign asleep               = q.pwr != spi_sleep_pkg::PWR_RUN;

   // ==========================================================
   // Assertions
   localparam int WAKE_BOUND  = `WAKE_CYC;
   localparam int GUARD_BOUND = `GUARD_CYC;

   sequence s_byte_awake;
      done && !q.fault && q.pwr == spi_sleep_pkg::PWR_RUN;
   endsequence
   sequence s_flags_up;
      q.buffer_full_flag && q.port_interrupt_flag;
   endsequence

   a_full_on_byte: assert property (@(posedge core_clk) disable iff (!rst_n)
      s_byte_awake |=> s_flags_up)
      else $error("byte done without full and interrupt flags");
   a_toggle_on_byte: assert property (@(posedge core_clk) disable iff (!rst_n)
      s_byte_awake |=> done_toggle != $past(done_toggle))
      else $error("spare output did not toggle");
   a_fault_keeps_buf: assert property (@(posedge core_clk)
      disable iff (!rst_n) done && q.fault && !buf_wr
      |=> serial_buffer == $past(serial_buffer))
      else $error("faulty byte overwrote buffer");
   a_fault_msb_out: assert property (@(posedge core_clk) disable iff (!rst_n)
      q.fault |-> sdo_out == serial_buffer[7])
      else $error("fault case not sending queued msb");
   a_lost_on_release: assert property (@(posedge core_clk)
      disable iff (!rst_n) q.pwr == spi_sleep_pkg::PWR_WAKE && q.pend
      && gated && ss_rel |=> !q.pend && !$rose(buffer_full_flag))
      else $error("released byte still delivered");
   a_sleep_guard_wait: assert property (@(posedge core_clk)
      disable iff (!rst_n) $rose(asleep) && sleep_guard_en && gated && sel
      |-> $past(q.ss_age) >= GUARD_BOUND)
      else $error("sleep entered inside guard time");
   a_write_collision_flag_no_abort: assert property (@(posedge core_clk) disable iff (!rst_n)
      go && busy && !sample |=> q.cnt == $past(q.cnt) || $past(!sel))
      else $error("sleep disturbed shift count");
   a_write_collision_flag_spurious: assert property (@(posedge core_clk) disable iff (!rst_n)
      go && busy && free && !clk_edge_sel |=> write_collision_flag)
      else $error("collision flag not set in free mode");
   a_gated_idle: assert property (@(posedge core_clk) disable iff (!rst_n)
      gated && q.ss_s[1] |=> q.cnt == 4'h0)
      else $error("shifter moved with select high");
   a_disable_clear: assert property (@(posedge core_clk) disable iff (!rst_n)
      !port_enable_bit |=> q.cnt == 4'h0 && !q.ss_cont)
      else $error("disable left transfer state");
   a_wake_bound: assert property (@(posedge core_clk) disable iff (!rst_n)
      $rose(q.pwr == spi_sleep_pkg::PWR_WAKE)
      |-> ##[1:WAKE_BOUND] q.pwr == spi_sleep_pkg::PWR_RUN)
      else $error("wake-up overran its time");
   a_set_beats_clear: assert property (@(posedge core_clk)
      disable iff (!rst_n) s_byte_awake and pif_clr |=> s_flags_up)
      else $error("flag clear won over set");
endmodule : spi_slave_sleep_port

//--- dv/spi_master_model.sv
// Behavioural SPI master that clocks the slave port
`timescale 1ns/1ps
module spi_master_model (
   input  wire logic core_clk,
   input  wire logic sdo_out,
   output logic      sclk_pin,
   output logic      ss_n_pin,
   output logic      sdi_pin
);
   initial begin
      sclk_pin = 1'b0;
      ss_n_pin = 1'b1;
      sdi_pin  = 1'b0;
   end
   task automatic sel;
      @(posedge core_clk);
      ss_n_pin <= 1'b0;
   endtask : sel
   // Released select goes to its pull-up level
   task automatic rel;
      @(posedge core_clk);
      ss_n_pin <= 1'b1;
   endtask : rel
   // Half period of four core cycles, clock still between frames
   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--) begin
         @(posedge core_clk);
         sdi_pin <= tx[i];
         repeat (3) @(posedge core_clk);
         rx[i] = sdo_out;
         sclk_pin <= 1'b1;
         repeat (4) @(posedge core_clk);
         sclk_pin <= 1'b0;
      end
      // Data is not held past the frame, so show its inverse
      @(posedge core_clk);
      sdi_pin <= ~sdi_pin;
   endtask : xfer
endmodule : spi_master_model

//--- dv/test_spi_slave_sleep_port.sv
// Self-checking bench of the sleep-aware SPI slave port
`timescale 1ns/1ps
module test_spi_slave_sleep_port;
   logic       core_clk, reset_n, sclk_pin, ss_n_pin, sdi_pin;
   logic       sdo_out, sdo_oe_n, port_enable_bit, clk_edge_sel;
   logic       sleep_exec, sleep_guard_en, buf_wr, buf_rd, pif_clr, write_collision_flag_clr;
   logic [3:0] port_mode_field;
   logic [7:0] buf_wdata, serial_buffer, rx;
   logic       buffer_full_flag, port_interrupt_flag, write_collision_flag;
   logic       done_toggle, asleep, tg;
   int         num_errors = 0;
   int         total_checks = 0;
   spi_slave_sleep_port u_spi_slave_sleep_port (.core_clk, .reset_n,
      .sclk_pin, .ss_n_pin, .sdi_pin, .sdo_out, .sdo_oe_n, .port_enable_bit,
      .port_mode_field, .clk_edge_sel, .sleep_exec, .sleep_guard_en, .buf_wr,
      .buf_wdata, .buf_rd, .pif_clr, .write_collision_flag_clr, .serial_buffer,
      .buffer_full_flag, .port_interrupt_flag, .write_collision_flag,
      .done_toggle, .asleep);
   spi_master_model u_spi_master_model (.core_clk, .sdo_out, .sclk_pin,
      .ss_n_pin, .sdi_pin);
   // ==========================================================
   // Helpers
   task automatic check(input string what, input logic [7:0] seen, exp);
      total_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
   endtask : cyc
   task automatic wr(input logic [7:0] d);
      @(posedge core_clk);
      buf_wr    <= 1'b1;
      buf_wdata <= d;
      @(posedge core_clk);
      buf_wr <= 1'b0;
   endtask : wr
   task automatic clr;
      @(posedge core_clk);
      {buf_rd, pif_clr, write_collision_flag_clr} <= 3'b111;
      @(posedge core_clk);
      {buf_rd, pif_clr, write_collision_flag_clr} <= 3'b000;
   endtask : clr
   task automatic nap;
      @(posedge core_clk);
      sleep_exec <= 1'b1;
      @(posedge core_clk);
      sleep_exec <= 1'b0;
   endtask : nap
   task automatic flags(input logic [2:0] exp);
      check("flags", {5'h00, buffer_full_flag, port_interrupt_flag,
         write_collision_flag}, {5'h00, exp});
   endtask : flags
   task automatic end_of_test;
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : end_of_test
   // ==========================================================
   // Clock, watchdog, tests
   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end
   initial begin
      cyc(20000);
      num_errors++;
      end_of_test;
   end
   initial begin
      reset_n = 1'b0;
      {port_enable_bit, clk_edge_sel} = 2'b11;
      {sleep_exec, sleep_guard_en, buf_wr, buf_rd, pif_clr, write_collision_flag_clr} = 6'h00;
      port_mode_field = 4'h4;
      buf_wdata = 8'h00;
      cyc(10);
      reset_n <= 1'b1;
      cyc(3);
      check("buffer", serial_buffer, 8'h00);
      flags(3'b000);
      tg = done_toggle;
      wr(8'ha5);
      u_spi_master_model.sel;
      u_spi_master_model.xfer(8'h3c, rx);
      cyc(6);
      u_spi_master_model.rel;
      check("rx", rx, 8'ha5);
      check("buffer", serial_buffer, 8'h3c);
      flags(3'b110);
      check("toggle", {7'h00, done_toggle}, {7'h00, ~tg});
      clr;
      u_spi_master_model.xfer(8'h5a, rx);
      cyc(6);
      flags(3'b000);
      port_mode_field <= 4'h5;
      u_spi_master_model.xfer(8'h5a, rx);
      cyc(6);
      check("buffer", serial_buffer, 8'h5a);
      flags(3'b110);
      clr;
      port_mode_field <= 4'h4;
      // Write in mid-byte is refused but must not break the byte
      u_spi_master_model.sel;
      fork
         u_spi_master_model.xfer(8'h11, rx);
         begin
            cyc(12);
            wr(8'h77);
         end
      join
      cyc(6);
      check("buffer", serial_buffer, 8'h11);
      flags(3'b111);
      clr;
      // Select held over two bytes, Sleep in the second
      u_spi_master_model.xfer(8'h21, rx);
      cyc(6);
      clr;
      fork
         u_spi_master_model.xfer(8'hc3, rx);
         begin
            cyc(10);
            nap;
         end
      join
      cyc(2);
      check("asleep", {7'h00, asleep}, 8'h01);
      cyc(60);
      check("asleep", {7'h00, asleep}, 8'h00);
      check("buffer", serial_buffer, 8'hc3);
      flags(3'b111);
      u_spi_master_model.rel;
      clr;
      // Select released before the wake-up completes
      nap;
      u_spi_master_model.sel;
      u_spi_master_model.xfer(8'h66, rx);
      cyc(2);
      u_spi_master_model.rel;
      cyc(60);
      check("buffer", serial_buffer, 8'hc3);
      flags(3'b000);
      // Select just before Sleep, with and without the guard
      for (int g = 0; g < 2; g++) begin
         sleep_guard_en <= g[0];
         wr(8'h80);
         u_spi_master_model.sel;
         cyc(2);
         nap;
         cyc(3);
         if (g == 1) check("asleep", {7'h00, asleep}, 8'h00);
         u_spi_master_model.xfer(8'h4b, rx);
         cyc(60);
         u_spi_master_model.rel;
         check("rx", rx, (g == 0) ? 8'hff : 8'h80);
         check("buffer", serial_buffer, (g == 0) ? 8'h80 : 8'h4b);
         clr;
      end
      // Port enable cycled between held-select bytes: no spurious flag
      sleep_guard_en <= 1'b0;
      u_spi_master_model.sel;
      u_spi_master_model.xfer(8'h12, rx);
      cyc(6);
      port_enable_bit <= 1'b0;
      cyc(2);
      port_enable_bit <= 1'b1;
      clr;
      fork
         u_spi_master_model.xfer(8'h34, rx);
         begin
            cyc(10);
            nap;
         end
      join
      cyc(60);
      check("rx", rx, 8'h12);
      check("buffer", serial_buffer, 8'h34);
      flags(3'b110);
      u_spi_master_model.rel;
      clr;
      // Select ignored, falling-edge sampling, Sleep in mid-byte
      port_mode_field <= 4'h5;
      clk_edge_sel    <= 1'b0;
      fork
         u_spi_master_model.xfer(8'h9d, rx);
         begin
            cyc(12);
            nap;
         end
      join
      cyc(60);
      check("rx", rx, 8'h34);
      check("buffer", serial_buffer, 8'h9d);
      flags(3'b111);
      end_of_test;
   end
endmodule : test_spi_slave_sleep_port
